// >>> verilog/dcadc_serial_ctrl.sv
// Purpose: serial framing, channel select and result shift-out of the converter
// Assumes: csN, sclk, sdi synchronous to clk; result supplied by the analog core
// Notes: serial edges are found by comparing sclk with its value one clk earlier
`timescale 1ns/100ps
`include "dcadc_defs.svh"
module dcadc_serial_ctrl #(
    parameter int RESULT_W = `DCADC_RESULT_BITS,
    parameter int CONV_CYCLES = `DCADC_CYCLES_PER_CONV
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // serial link
    input wire logic csN,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    // analog core
    input wire logic [RESULT_W-1:0] convResult,
    output logic chanSel,
    output logic sampleStrobe,
    output logic trackActive,
    output logic powerUp
);
    localparam int CW = $clog2(CONV_CYCLES);

    logic sclkPrev_q;
    logic csPrev_q;
    logic [CW-1:0] edgeCnt_q;
    logic [CW-1:0] edgeCnt_d;
    logic [`DCADC_CTRL_BITS-1:0] ctrlShift_q;
    logic nextChan_q;
    logic curChan_q;
    logic [RESULT_W-1:0] outShift_q;
    logic sdo_q;
    logic convDone_q;
    dcadc_pkg::dcadc_phase_t phase_q;
    dcadc_pkg::dcadc_phase_t phase_d;

    wire frameOn = ~csN;
    wire frameStart = csPrev_q & ~csN;
    wire sclkRise = frameOn & sclk & ~sclkPrev_q;
    // a frame opening with sclk low counts as the first falling edge
    wire sclkFall = frameOn & ((~sclk & sclkPrev_q) | (frameStart & ~sclk));
    wire lastRise = sclkRise && (edgeCnt_q == CW'(CONV_CYCLES - 1));
    wire ctrlWindow = sclkRise && (edgeCnt_q < CW'(`DCADC_CTRL_BITS));
    wire ctrlLast = sclkRise && (edgeCnt_q == CW'(`DCADC_CTRL_BITS - 1));
    wire [`DCADC_CTRL_BITS-1:0] ctrlWord = {ctrlShift_q[`DCADC_CTRL_BITS-2:0], sdi};
    // only select bits 4 and 3 are decoded; bit 5 and the rest are dropped
    wire selMid = ctrlWord[`DCADC_SEL_MID_POS];
    wire selLo = ctrlWord[`DCADC_SEL_LO_POS];
    // bit 4 high is illegal; its channel falls back to input a whatever bit 3 is, and output is garbage-free
    wire decodedChan = selLo & ~selMid;
    // hold starts at the fourth falling edge
    wire holdEdge = sclkFall && (edgeCnt_q == CW'(`DCADC_TRACK_CYCLES));
    // msb launched on the falling edge after the fourth rise, valid at fifth clock
    wire loadEdge = sclkFall && (edgeCnt_q == CW'(`DCADC_FIRST_DATA_CLK - 1));
    wire shiftEdge = sclkFall && (edgeCnt_q > CW'(`DCADC_FIRST_DATA_CLK - 1));

    always_comb begin
        edgeCnt_d = edgeCnt_q;
        if (!frameOn) begin
            edgeCnt_d = '0;
        end else if (sclkRise) begin
            edgeCnt_d = lastRise ? '0 : edgeCnt_q + CW'(1);
        end
    end

    always_comb begin
        phase_d = phase_q;
        if (!frameOn) begin
            phase_d = dcadc_pkg::PH_IDLE;
        end else if (holdEdge) begin
            phase_d = dcadc_pkg::PH_CONVERT;
        end else if (sclkFall && edgeCnt_q == '0) begin
            phase_d = dcadc_pkg::PH_TRACK;
        end else if (lastRise) begin
            phase_d = dcadc_pkg::PH_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
            edgeCnt_q <= '0;
            phase_q <= dcadc_pkg::PH_IDLE;
        end else begin
            sclkPrev_q <= sclk;
            csPrev_q <= csN;
            edgeCnt_q <= edgeCnt_d;
            phase_q <= phase_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlShift_q <= '0;
            nextChan_q <= `DCADC_CHAN_RESET;
            curChan_q <= `DCADC_CHAN_RESET;
        end else begin
            if (ctrlWindow) begin
                ctrlShift_q <= ctrlWord;
            end
            if (ctrlLast) begin
                nextChan_q <= decodedChan;
            end
            if (lastRise) begin
                curChan_q <= nextChan_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outShift_q <= '0;
            sdo_q <= 1'b0;
            convDone_q <= 1'b0;
        end else begin
            convDone_q <= holdEdge;
            if (loadEdge) begin
                // straight binary, msb first
                outShift_q <= {convResult[RESULT_W-2:0], 1'b0};
                sdo_q <= convResult[RESULT_W-1];
            end else if (shiftEdge) begin
                sdo_q <= outShift_q[RESULT_W-1];
                outShift_q <= {outShift_q[RESULT_W-2:0], 1'b0};
            end else if (sclkFall && edgeCnt_q == '0) begin
                sdo_q <= 1'b0;
            end
        end
    end

    assign sdo = sdo_q;
    assign sdoOe = frameOn;
    assign chanSel = curChan_q;
    assign sampleStrobe = convDone_q;
    assign trackActive = (phase_q == dcadc_pkg::PH_TRACK);
    assign powerUp = frameOn && (phase_q != dcadc_pkg::PH_IDLE);

    a_oe_follows_cs: assert property (@(posedge clk) disable iff (rst) sdoOe == !csN)
        else $error("output enable does not follow chip select");
    a_idle_when_cs_high: assert property (@(posedge clk) disable iff (rst) csN |=> !powerUp)
        else $error("powered while chip select high");
    a_count_wraps_16: assert property (@(posedge clk) disable iff (rst)
        lastRise |=> edgeCnt_q == '0)
        else $error("conversion count did not wrap");
    a_idle_after_last: assert property (@(posedge clk) disable iff (rst)
        lastRise && !holdEdge |=> phase_q == dcadc_pkg::PH_IDLE)
        else $error("no power down after conversion");
    a_chan_next_conv: assert property (@(posedge clk) disable iff (rst)
        lastRise |=> curChan_q == $past(nextChan_q))
        else $error("channel not advanced at conversion boundary");
    a_select_decode: assert property (@(posedge clk) disable iff (rst)
        ctrlLast |=> nextChan_q == ($past(ctrlShift_q[2]) && !$past(ctrlShift_q[3])))
        else $error("channel select decoded wrongly");
    a_hold_at_fourth: assert property (@(posedge clk) disable iff (rst)
        holdEdge && frameOn |=> phase_q == dcadc_pkg::PH_CONVERT)
        else $error("hold not entered at fourth falling edge");
    a_msb_first: assert property (@(posedge clk) disable iff (rst)
        loadEdge |=> sdo == $past(convResult[RESULT_W-1]))
        else $error("result msb not first");

    // strobes per conversion; a second one means a lost conversion boundary
    logic [1:0] stbInConv_q;

    always_ff @(posedge clk) begin
        if (rst || !frameOn || lastRise) begin
            stbInConv_q <= 2'h0;
        end else if (sampleStrobe && stbInConv_q != 2'h3) begin
            stbInConv_q <= stbInConv_q + 2'h1;
        end
    end

    // framing, phase and output ordering guards
    a_strobe_after_hold: assert property (@(posedge clk) disable iff (rst)
        holdEdge |=> sampleStrobe)
        else $error("no sample strobe after hold");
    a_strobe_single: assert property (@(posedge clk) disable iff (rst)
        sampleStrobe |=> !sampleStrobe)
        else $error("sample strobe longer than one cycle");
    a_one_strobe_conv: assert property (@(posedge clk) disable iff (rst)
        stbInConv_q <= 2'h1)
        else $error("more than one sample per conversion");
    a_track_at_fall: assert property (@(posedge clk) disable iff (rst)
        sclkFall && edgeCnt_q == '0 |=> trackActive)
        else $error("track not entered at first falling edge");
    a_idle_no_track: assert property (@(posedge clk) disable iff (rst)
        !frameOn |=> !trackActive)
        else $error("tracking while chip select high");
    a_powered_conv: assert property (@(posedge clk) disable iff (rst)
        frameOn && phase_q == dcadc_pkg::PH_CONVERT |-> powerUp)
        else $error("not powered during conversion");
    a_gap_power_down: assert property (@(posedge clk) disable iff (rst)
        lastRise |=> !powerUp)
        else $error("still powered after the last rise");
    a_sdo_shift: assert property (@(posedge clk) disable iff (rst)
        shiftEdge |=> sdo == $past(outShift_q[RESULT_W-1]))
        else $error("result bit order broken");
    a_sdo_gap_zero: assert property (@(posedge clk) disable iff (rst)
        sclkFall && edgeCnt_q == '0 |=> sdo == 1'b0)
        else $error("output not cleared at conversion start");
    a_count_clear: assert property (@(posedge clk) disable iff (rst)
        !frameOn |=> edgeCnt_q == '0)
        else $error("edge count kept outside frame");
    a_rise_counts: assert property (@(posedge clk) disable iff (rst)
        sclkRise && !lastRise |=> edgeCnt_q == $past(edgeCnt_q) + CW'(1))
        else $error("rise not counted");
    a_chan_stable: assert property (@(posedge clk) disable iff (rst)
        !lastRise |=> $stable(curChan_q))
        else $error("channel moved inside a conversion");
    a_next_stable: assert property (@(posedge clk) disable iff (rst)
        !ctrlLast |=> $stable(nextChan_q))
        else $error("pending channel moved outside control word");
    a_ctrl_capture: assert property (@(posedge clk) disable iff (rst)
        ctrlWindow |=> ctrlShift_q == $past(ctrlWord))
        else $error("control bit not captured");
    a_illegal_sel_a: assert property (@(posedge clk) disable iff (rst)
        ctrlLast && ctrlWord[`DCADC_SEL_MID_POS] |=> !nextChan_q)
        else $error("illegal select did not fall back to input a");
endmodule : dcadc_serial_ctrl

// >>> verilog/dcadc_defs.svh
// Purpose: constants for the two-channel converter serial control block
// Assumes: serial pins sampled synchronously on clk (200 MHz)
// Notes: field positions are bit indices of the 8-bit control word
// Summary of operation
// - only control bits 4..3 matter
// - select applies to the next conversion
// - bit4=0: bit3 picks input a/b
// - result is 10-bit straight binary
// - powered while chip select low only
// - power down after 16th rising edge
// - conversion is 16 serial clocks
// - conversions repeat while chip select low
// - rate is serial clock over 16
// - control word sampled on first 8 rises
// - track 3 cycles, hold/convert 13
// - result MSB first from fifth clock
`ifndef DCADC_DEFS_SVH
`define DCADC_DEFS_SVH
`define DCADC_CYCLES_PER_CONV 16
`define DCADC_CTRL_BITS 8
`define DCADC_TRACK_CYCLES 3
`define DCADC_FIRST_DATA_CLK 5
`define DCADC_SEL_HI_POS 5
`define DCADC_SEL_MID_POS 4
`define DCADC_SEL_LO_POS 3
`define DCADC_CHAN_RESET 1'b0
`define DCADC_RESULT_BITS 10
`endif

// >>> verilog/dcadc_pkg.sv
// Purpose: types for the converter serial control block
// Assumes: used with dcadc_defs.svh
// Notes: phase is one-hot
package dcadc_pkg;
    typedef enum logic [2:0] {
        PH_TRACK = 3'b001,
        PH_CONVERT = 3'b010,
        PH_IDLE = 3'b100
    } dcadc_phase_t;
endpackage : dcadc_pkg

// >>> tb/dcadc_host.sv
// Purpose: host serial port model for the converter link
// Assumes: sclk idles low and stands still outside frames
// Notes: tasks are called from tb by hierarchical name
`timescale 1ns/100ps
module dcadc_host #(
    parameter int HALF = 32 // 64 clk period, 3.125 MHz
) (
    // system
    input wire logic clk,
    // serial link
    output logic csN,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // sclk low here, so this fall is the first falling edge
    task automatic open_frame();
        @(negedge clk);
        csN = 1'b0;
    endtask : open_frame
    task automatic close_frame();
        repeat (HALF) @(negedge clk);
        csN = 1'b1;
        sdi = ~sdi; // released line shows no stale value
    endtask : close_frame
    // n rises; result bits taken at rises 5..14
    task automatic conv(input logic [7:0] ctrl, input int n, output logic [9:0] res);
        res = 10'h000;
        for (int k = 0; k < n; k++) begin
            sdi = (k < 8) ? ctrl[7-k] : ~sdi;
            repeat (HALF) @(negedge clk);
            if (k >= 4 && k < 14) res = {res[8:0], sdo};
            sclk = 1'b1;
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
    endtask : conv
endmodule : dcadc_host

// >>> tb/tb.sv
// Purpose: self-checking bench for the converter serial control block
// Assumes: core result follows chanSel
// Notes: monitors sample at negedge, where outputs are settled
`timescale 1ns/100ps
module tb;
    localparam logic [9:0] resA = 10'h2A5;
    localparam logic [9:0] resB = 10'h3FF;
    logic clk, rst, csN, sclk, sdi, sdo, sdoOe, chanSel, sampleStrobe, trackActive, powerUp;
    logic [9:0] r;
    logic [9:0] convResult;
    int failCount = 0, testsRun = 0, cyc = 0, strobes = 0, offCnt = 0, trackCnt = 0;
    assign convResult = (chanSel === 1'b1) ? resB : resA;
    dcadc_serial_ctrl dut (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdoOe(sdoOe), .convResult(convResult), .chanSel(chanSel), .sampleStrobe(sampleStrobe),
        .trackActive(trackActive), .powerUp(powerUp));
    // released line shows the inverse, so a stale bit cannot pass
    wire sdoLine = sdoOe ? sdo : ~sdo;
    dcadc_host host (.clk(clk), .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdoLine));
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        testsRun++;
        if (g !== e) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) begin
        #1; // host drives on this edge too; let its changes settle
        cyc++;
        if (csN === 1'b0 && powerUp === 1'b0) offCnt++;
        if (csN === 1'b0 && trackActive === 1'b1) trackCnt++;
        if (sampleStrobe === 1'b1) strobes++;
        if (rst === 1'b0) chk("sdoOe", {9'h000, ~csN}, {9'h000, sdoOe});
        if (rst === 1'b0 && csN) chk("powerUp", 10'h000, {9'h000, powerUp});
        if (cyc == 20000) begin
            failCount++;
            stop_test();
        end
    end
    task automatic t_chain();
        host.open_frame();
        host.conv(8'hEF, 16, r); // bit 4 kept low in every word
        chk("res1", resA, r);
        host.conv(8'h27, 16, r);
        chk("res2", resB, r);
        host.conv(8'hC8, 16, r);
        chk("res3", resA, r);
        host.close_frame();
        chk("chanSel", 10'h001, {9'h000, chanSel});
        chk("strobes", 10'h003, 10'(strobes));
        chk("track", 10'h001, {9'h000, trackCnt >= 570 && trackCnt <= 620});
        chk("gap", 10'h001, {9'h000, offCnt >= 90 && offCnt <= 110});
    endtask : t_chain
    // frame cut after 10 rises must not move the channel
    task automatic t_abort();
        host.open_frame();
        host.conv(8'h00, 10, r);
        host.close_frame();
        chk("chanHeld", 10'h001, {9'h000, chanSel});
        host.open_frame();
        host.conv(8'h00, 16, r);
        host.close_frame();
        chk("resAfterCut", resB, r);
        chk("chanA", 10'h000, {9'h000, chanSel});
    endtask : t_abort
    initial begin
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk("chanReset", 10'h000, {9'h000, chanSel});
        t_chain();
        t_abort();
        stop_test();
    end
endmodule : tb
